// *** inc/ectq_regs.vh ***
/*
  Register offsets, field positions, reset values and encodings of the
  edge count timer. Included by every design file of the timer.
*/
`ifndef ECTQ_REGS_VH
`define ECTQ_REGS_VH

// ****************************************************************
// Register offsets (byte addresses on the plain register port)
// ****************************************************************
`define ECTQ_ADDR_W        6
`define ECTQ_OFS_CTL       6'h00
`define ECTQ_OFS_CFG       6'h04
`define ECTQ_OFS_ILR_A     6'h08
`define ECTQ_OFS_ILR_B     6'h0c
`define ECTQ_OFS_MATCH_A   6'h10
`define ECTQ_OFS_MATCH_B   6'h14
`define ECTQ_OFS_PRE_A     6'h18
`define ECTQ_OFS_PRE_B     6'h1c
`define ECTQ_OFS_CNT_A     6'h20
`define ECTQ_OFS_CNT_B     6'h24
`define ECTQ_OFS_STAT      6'h28

// ****************************************************************
// Control register fields
// ****************************************************************
`define ECTQ_CTL_RUN_A     0
`define ECTQ_CTL_RUN_B     8
`define ECTQ_CTL_DMA_A     5
`define ECTQ_CTL_DMA_B     13

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define ECTQ_CFG_W32       0
`define ECTQ_CFG_MODE_A_LO 1
`define ECTQ_CFG_MODE_A_HI 2
`define ECTQ_CFG_MODE_B_LO 3
`define ECTQ_CFG_MODE_B_HI 4
`define ECTQ_CFG_UP_A      5
`define ECTQ_CFG_UP_B      6
`define ECTQ_CFG_EDGE_A_LO 7
`define ECTQ_CFG_EDGE_A_HI 8
`define ECTQ_CFG_EDGE_B_LO 9
`define ECTQ_CFG_EDGE_B_HI 10
`define ECTQ_CFG_W         11

// ****************************************************************
// Mode and edge encodings
// ****************************************************************
`define ECTQ_MODE_W        2
`define ECTQ_MODE_PERIODIC 2'h0
`define ECTQ_MODE_ECOUNT   2'h1
`define ECTQ_MODE_ETIME    2'h2
`define ECTQ_MODE_RTC      2'h3
`define ECTQ_EDGE_RISE     2'h0
`define ECTQ_EDGE_FALL     2'h1
`define ECTQ_EDGE_BOTH     2'h3

// ****************************************************************
// Status register fields and reset values
// ****************************************************************
`define ECTQ_STAT_MATCH_A  0
`define ECTQ_STAT_MATCH_B  1
`define ECTQ_STAT_ROLL_A   2
`define ECTQ_STAT_ROLL_B   3
`define ECTQ_CNT_W         16
`define ECTQ_RST_ZERO16    16'h0000
`define ECTQ_RST_ONES16    16'hffff
`define ECTQ_RST_CTL       32'h0000_0000
`define ECTQ_RST_CFG       11'h000
`define ECTQ_ONE16         16'h0001
`define ECTQ_RD_ZERO       32'h0000_0000

`endif

// *** logic/ectq_edge_det.v ***
/*
  Edge qualifier for one capture pin: pulses for the selected edges.
  Assumes the pin is already synchronous to mclk.
*/
`default_nettype none
`include "ectq_regs.vh"

module ectq_edge_det (
  input  wire       mclk,   // System clock
  input  wire       rst,    // Synchronous reset, active high
  input  wire       pin,    // Capture pin level
  input  wire [1:0] sel,    // Edge selection
  output wire       evt     // One-cycle qualifying event
);

  reg pin_q;

  always @(posedge mclk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
    end
  end

  wire rise = pin & ~pin_q;
  wire fall = ~pin & pin_q;

  assign evt = (sel == `ECTQ_EDGE_RISE) ? rise :
               (sel == `ECTQ_EDGE_FALL) ? fall :
               (sel == `ECTQ_EDGE_BOTH) ? (rise | fall) : 1'b0;

endmodule
`default_nettype wire

// *** logic/ectq_half.v ***
/*
  One 16-bit timer half: counter, match, rollover and the known quirks.
  Assumes strobes from the register file are one cycle long.
*/
`default_nettype none
`include "ectq_regs.vh"

module ectq_half (
  input  wire        mclk,        // System clock
  input  wire        rst,         // Synchronous reset, active high
  input  wire        run,         // Timer run bit
  input  wire [1:0]  mode,        // Operating mode
  input  wire        up,          // Count direction, 1 = up
  input  wire        evt,         // Qualifying pin event
  input  wire        ld_wr,       // Interval load write strobe
  input  wire [15:0] ld_val,      // Interval load value
  input  wire        step_wr,     // Match or prescale write strobe
  input  wire [15:0] match_val,   // Match value (low half only)
  output reg  [15:0] cnt_q,       // Counter value
  output reg         match_q,     // Match pulse
  output reg         roll_q       // Rollover pulse
);

  reg         run_q;
  reg  [15:0] cnt_d;
  wire        ev_mode = (mode == `ECTQ_MODE_ECOUNT) || (mode == `ECTQ_MODE_ETIME);
  wire        stepper = (mode == `ECTQ_MODE_RTC) || (mode == `ECTQ_MODE_ECOUNT);
  wire        stop    = run_q & ~run & (mode == `ECTQ_MODE_ECOUNT);
  wire        term    = up ? (cnt_q == `ECTQ_RST_ONES16) : (cnt_q == `ECTQ_RST_ZERO16);

  always @* begin
    cnt_d = cnt_q;
    if (ld_wr) begin
      cnt_d = ld_val;
    end else if (stop) begin
      cnt_d = cnt_q - `ECTQ_ONE16;
    end else if (run && ((evt && ev_mode) || (step_wr && stepper))) begin
      // No reload after a match, count simply moves on
      cnt_d = up ? cnt_q + `ECTQ_ONE16 : cnt_q - `ECTQ_ONE16;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      run_q   <= 1'b0;
      cnt_q   <= `ECTQ_RST_ONES16;
      match_q <= 1'b0;
      roll_q  <= 1'b0;
    end else begin
      run_q   <= run;
      cnt_q   <= cnt_d;
      // Only 16 bits are compared, even when paired as 32 bits
      match_q <= run & ev_mode & evt & (cnt_d == match_val) & (cnt_d != cnt_q);
      roll_q  <= run & (mode == `ECTQ_MODE_ETIME) & evt & term;
    end
  end

endmodule
`default_nettype wire

// *** logic/ectq_top.v ***
/*
  Edge count timer with two halves, register port and DMA requests.
  Assumes capture pins are synchronous to mclk; software keeps its
  own workarounds for stop, reload and spurious DMA requests.
*/
// The plain strobed port and the register addresses were left to the implementer.
// Behaviour
// - Clearing run in edge count decrements once
// - Pin events step counter in edge count and edge time, down unless up set; match raises interrupt
// - No reload of interval after match
// - 32-bit match compares only low half
// - Edge time rollover raises spurious DMA request
// - Match or prescale write steps counter in RTC and edge count modes while running
`default_nettype none
`include "ectq_regs.vh"

module ectq_top (
  input  wire        mclk,      // System clock, 250 MHz
  input  wire        rst,       // Synchronous reset, active high
  input  wire [5:0]  addr,      // Register byte address
  input  wire [31:0] wdata,     // Write data
  input  wire        wr,        // Write strobe
  input  wire        rd,        // Read strobe
  output reg  [31:0] rdata,     // Read data, one cycle after rd
  input  wire        ccp_a,     // Capture compare pin A
  input  wire        ccp_b,     // Capture compare pin B
  output wire        irq,       // Match interrupt, level
  output wire        dma_a,     // DMA request A, one-cycle pulse
  output wire        dma_b      // DMA request B, one-cycle pulse
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [31:0] ctl_q;
  reg  [10:0] cfg_q;
  reg  [15:0] ilr_a_q, ilr_b_q, mat_a_q, mat_b_q, pre_a_q, pre_b_q;
  reg  [3:0]  stat_q;
  reg  [31:0] rdata_d;
  wire [15:0] cnt_a, cnt_b;
  wire        m_a, m_b, r_a, r_b, ev_a, ev_b;

  wire wr_ila = wr && (addr == `ECTQ_OFS_ILR_A);
  wire wr_ilb = wr && (addr == `ECTQ_OFS_ILR_B);
  wire wr_ma  = wr && (addr == `ECTQ_OFS_MATCH_A);
  wire wr_mb  = wr && (addr == `ECTQ_OFS_MATCH_B);
  wire wr_pa  = wr && (addr == `ECTQ_OFS_PRE_A);
  wire wr_pb  = wr && (addr == `ECTQ_OFS_PRE_B);
  wire wr_st  = wr && (addr == `ECTQ_OFS_STAT);

  wire w32    = cfg_q[`ECTQ_CFG_W32];

  always @(posedge mclk) begin
    if (rst) begin
      ctl_q   <= `ECTQ_RST_CTL;
      cfg_q   <= `ECTQ_RST_CFG;
      ilr_a_q <= `ECTQ_RST_ONES16;
      ilr_b_q <= `ECTQ_RST_ONES16;
      mat_a_q <= `ECTQ_RST_ZERO16;
      mat_b_q <= `ECTQ_RST_ZERO16;
      pre_a_q <= `ECTQ_RST_ZERO16;
      pre_b_q <= `ECTQ_RST_ZERO16;
    end else if (wr) begin
      case (addr)
        `ECTQ_OFS_CTL:     ctl_q   <= wdata;
        `ECTQ_OFS_CFG:     cfg_q   <= wdata[`ECTQ_CFG_W-1:0];
        `ECTQ_OFS_ILR_A:   ilr_a_q <= wdata[15:0];
        `ECTQ_OFS_ILR_B:   ilr_b_q <= wdata[15:0];
        `ECTQ_OFS_MATCH_A: mat_a_q <= wdata[15:0];   // Upper half dropped
        `ECTQ_OFS_MATCH_B: mat_b_q <= wdata[15:0];
        `ECTQ_OFS_PRE_A:   pre_a_q <= wdata[15:0];
        `ECTQ_OFS_PRE_B:   pre_b_q <= wdata[15:0];
        default:           ctl_q   <= ctl_q;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  wire [3:0] st_set = {r_b, r_a, m_b, m_a};
  always @(posedge mclk) begin
    if (rst) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (stat_q & ~(wr_st ? wdata[3:0] : 4'h0)) | st_set;
    end
  end

  assign irq = stat_q[`ECTQ_STAT_MATCH_A] | stat_q[`ECTQ_STAT_MATCH_B];

  // ****************************************************************
  // DMA requests
  // ****************************************************************
  // Rollover request is deliberately passed: software filters it
  assign dma_a = ctl_q[`ECTQ_CTL_DMA_A] & (m_a | r_a);
  assign dma_b = ctl_q[`ECTQ_CTL_DMA_B] & (m_b | r_b);

  // ****************************************************************
  // Timer halves
  // ****************************************************************
  ectq_edge_det u_eda (
    .mclk (mclk),
    .rst  (rst),
    .pin  (ccp_a),
    .sel  (cfg_q[`ECTQ_CFG_EDGE_A_HI:`ECTQ_CFG_EDGE_A_LO]),
    .evt  (ev_a)
  );

  ectq_edge_det u_edb (
    .mclk (mclk),
    .rst  (rst),
    .pin  (ccp_b),
    .sel  (cfg_q[`ECTQ_CFG_EDGE_B_HI:`ECTQ_CFG_EDGE_B_LO]),
    .evt  (ev_b)
  );

  ectq_half u_ha (
    .mclk      (mclk),
    .rst       (rst),
    .run       (ctl_q[`ECTQ_CTL_RUN_A]),
    .mode      (cfg_q[`ECTQ_CFG_MODE_A_HI:`ECTQ_CFG_MODE_A_LO]),
    .up        (cfg_q[`ECTQ_CFG_UP_A]),
    .evt       (ev_a),
    .ld_wr     (wr_ila),
    .ld_val    (wdata[15:0]),
    .step_wr   (wr_ma | wr_pa),
    .match_val (mat_a_q),
    .cnt_q     (cnt_a),
    .match_q   (m_a),
    .roll_q    (r_a)
  );

  // In paired mode B is not used for matching, so A alone fires
  ectq_half u_hb (
    .mclk      (mclk),
    .rst       (rst),
    .run       (ctl_q[`ECTQ_CTL_RUN_B] & ~w32),
    .mode      (cfg_q[`ECTQ_CFG_MODE_B_HI:`ECTQ_CFG_MODE_B_LO]),
    .up        (cfg_q[`ECTQ_CFG_UP_B]),
    .evt       (ev_b),
    .ld_wr     (wr_ilb),
    .ld_val    (wdata[15:0]),
    .step_wr   (wr_mb | wr_pb),
    .match_val (mat_b_q),
    .cnt_q     (cnt_b),
    .match_q   (m_b),
    .roll_q    (r_b)
  );

  // ****************************************************************
  // Read port
  // ****************************************************************
  always @* begin
    rdata_d = `ECTQ_RD_ZERO;
    case (addr)
      `ECTQ_OFS_CTL:     rdata_d = ctl_q;
      `ECTQ_OFS_CFG:     rdata_d = {21'h00_0000, cfg_q};
      `ECTQ_OFS_ILR_A:   rdata_d = {16'h0000, ilr_a_q};
      `ECTQ_OFS_ILR_B:   rdata_d = {16'h0000, ilr_b_q};
      `ECTQ_OFS_MATCH_A: rdata_d = {16'h0000, mat_a_q};
      `ECTQ_OFS_MATCH_B: rdata_d = {16'h0000, mat_b_q};
      `ECTQ_OFS_PRE_A:   rdata_d = {16'h0000, pre_a_q};
      `ECTQ_OFS_PRE_B:   rdata_d = {16'h0000, pre_b_q};
      `ECTQ_OFS_CNT_A:   rdata_d = {16'h0000, cnt_a};
      `ECTQ_OFS_CNT_B:   rdata_d = {16'h0000, cnt_b};
      `ECTQ_OFS_STAT:    rdata_d = {28'h000_0000, stat_q};
      default:           rdata_d = `ECTQ_RD_ZERO;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      rdata <= `ECTQ_RD_ZERO;
    end else if (rd) begin
      rdata <= rdata_d;
    end else begin
      rdata <= `ECTQ_RD_ZERO;
    end
  end

endmodule
`default_nettype wire

// *** sim/ectq_pin_src.sv ***
/*
  External event source on the two capture pins.
  Assumes pins are sampled synchronously to mclk by the timer.
*/
`default_nettype none

module ectq_pin_src (
  input  wire logic mclk,    // System clock
  input  wire logic rst,     // Synchronous reset
  input  wire logic fire_a,  // Request one pulse on pin A
  input  wire logic fire_b,  // Request one pulse on pin B
  output var  logic ccp_a,   // Capture pin A
  output var  logic ccp_b    // Capture pin B
);
  timeunit 1ns;
  timeprecision 1ps;
  // One full-cycle high pulse per request gives exactly one rising edge
  always @(posedge mclk) begin
    ccp_a <= !rst && fire_a;
    ccp_b <= !rst && fire_b;
  end
endmodule

`default_nettype wire

// *** sim/ectq_top_checker.sv ***
/*
  Port-level timing checker for the edge count timer top.
  Assumes it is bound to ectq_top and sees only its ports.
*/
`default_nettype none
`include "ectq_regs.vh"

module ectq_top_checker (
  input wire logic        mclk,   // System clock
  input wire logic        rst,    // Synchronous reset
  input wire logic [5:0]  addr,   // Register address
  input wire logic [31:0] wdata,  // Write data
  input wire logic        wr,     // Write strobe
  input wire logic        rd,     // Read strobe
  input wire logic [31:0] rdata,  // Read data
  input wire logic        ccp_a,  // Capture pin A
  input wire logic        ccp_b,  // Capture pin B
  input wire logic        irq,    // Match interrupt
  input wire logic        dma_a,  // DMA request A
  input wire logic        dma_b   // DMA request B
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Port relations
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("rdata not zero outside read answer");
  chk_unmapped_read: assert property (rd && addr > `ECTQ_OFS_STAT |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_irq_cause: assert property ($rose(irq) |-> $past(wr) ||
    $past(ccp_a) != $past(ccp_a, 2) || $past(ccp_b) != $past(ccp_b, 2))
    else $error("irq rose without event or write");
  chk_irq_sticky: assert property (irq && !wr |=> irq)
    else $error("irq dropped without a write");
  chk_irq_clear: assert property ($fell(irq) |-> $past(wr) && $past(addr) == `ECTQ_OFS_STAT)
    else $error("irq fell without status write");
  chk_dma_a_cause: assert property (dma_a |-> $past(wr) ||
    $past(ccp_a) != $past(ccp_a, 2))
    else $error("dma_a without event or write");
  chk_dma_b_cause: assert property (dma_b |-> $past(wr) || $past(ccp_b) != $past(ccp_b, 2))
    else $error("dma_b without event or write");
  chk_dma_a_pulse: assert property (dma_a |=> !dma_a)
    else $error("dma_a longer than one cycle");

  cover property ($rose(irq));
  cover property (dma_a);
  cover property (dma_b);
endmodule

bind ectq_top ectq_top_checker ectq_top_checker_i (.mclk, .rst, .addr, .wdata, .wr, .rd,
  .rdata, .ccp_a, .ccp_b, .irq, .dma_a, .dma_b);

`default_nettype wire

// *** sim/ectq_top_tb_top.sv ***
/*
  Self-checking bench for the edge count timer.
  Assumes the checker binds itself and the pin source drives the pins.
*/
`default_nettype none
`include "ectq_regs.vh"

module ectq_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, wr, rd, fa, fb;
  logic [5:0]  addr;
  logic [31:0] wdata;
  wire  [31:0] rdata;
  wire         ccp_a, ccp_b, irq, dma_a, dma_b;
  logic [15:0] na, nb;
  int          err_count, total_checks;

  ectq_top ectq_top_i (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .ccp_a, .ccp_b, .irq, .dma_a, .dma_b);
  ectq_pin_src ectq_pin_src_i (.mclk, .rst, .fire_a(fa), .fire_b(fb), .ccp_a, .ccp_b);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Requests are single-cycle pulses, so counting cycles counts requests
  always @(posedge mclk) begin
    na <= rst ? 16'h0000 : na + {15'h0000, dma_a === 1'b1};
    nb <= rst ? 16'h0000 : nb + {15'h0000, dma_b === 1'b1};
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr_t(input logic [5:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd_c(input logic [5:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata[15:0], e);
    @(posedge mclk);
  endtask

  task automatic ev(input logic b);
    fa <= !b;
    fb <= b;
    @(posedge mclk);
    fa <= 1'b0;
    fb <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    stop_test;
  end

  initial begin
    {rst, wr, rd, fa, fb} = 5'h10;
    addr = 6'h00;
    wdata = 32'h0000_0000;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd_c(`ECTQ_OFS_CNT_A, 16'hffff);
    rd_c(`ECTQ_OFS_CTL, 16'h0000);
    rd_c(6'h2c, 16'h0000);
    wr_t(`ECTQ_OFS_CFG, 32'h0000_000a);
    wr_t(`ECTQ_OFS_ILR_A, 32'h0000_0005);
    wr_t(`ECTQ_OFS_ILR_B, 32'h0000_0002);
    wr_t(`ECTQ_OFS_MATCH_A, 32'h0000_0003);
    wr_t(`ECTQ_OFS_MATCH_B, 32'h0000_0001);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_2121);
    ev(1'b0);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0004);
    ev(1'b0);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0003);
    chk({15'h0000, irq}, 16'h0001);
    chk(na, 16'h0001);
    ev(1'b0);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0002);
    ev(1'b1);
    rd_c(`ECTQ_OFS_CNT_B, 16'h0001);
    chk(nb, 16'h0001);
    rd_c(`ECTQ_OFS_STAT, 16'h0003);
    wr_t(`ECTQ_OFS_PRE_A, 32'h0000_0007);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0001);
    wr_t(`ECTQ_OFS_MATCH_A, 32'h0000_00aa);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0000);
    wr_t(`ECTQ_OFS_STAT, 32'h0000_000f);
    chk({15'h0000, irq}, 16'h0000);
    wr_t(`ECTQ_OFS_ILR_A, 32'h0000_0010);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_2100);
    rd_c(`ECTQ_OFS_CNT_A, 16'h000f);
    ev(1'b0);
    rd_c(`ECTQ_OFS_CNT_A, 16'h000f);
    wr_t(`ECTQ_OFS_MATCH_A, 32'h0000_00bb);
    rd_c(`ECTQ_OFS_CNT_A, 16'h000f);
    wr_t(`ECTQ_OFS_ILR_A, 32'h0000_0010);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_2121);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0010);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_0000);
    wr_t(`ECTQ_OFS_CFG, 32'h0000_0003);
    wr_t(`ECTQ_OFS_ILR_A, 32'h0000_0009);
    wr_t(`ECTQ_OFS_MATCH_A, 32'habcd_0007);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_0021);
    ev(1'b0);
    ev(1'b0);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0007);
    chk({15'h0000, irq}, 16'h0001);
    chk(na, 16'h0002);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_0000);
    wr_t(`ECTQ_OFS_STAT, 32'h0000_000f);
    wr_t(`ECTQ_OFS_CFG, 32'h0000_0004);
    wr_t(`ECTQ_OFS_ILR_A, 32'h0000_0001);
    wr_t(`ECTQ_OFS_MATCH_A, 32'h0000_0100);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_0021);
    ev(1'b0);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0000);
    chk(na, 16'h0002);
    ev(1'b0);
    chk(na, 16'h0003);
    chk({15'h0000, irq}, 16'h0000);
    rd_c(`ECTQ_OFS_STAT, 16'h0004);
    wr_t(`ECTQ_OFS_ILR_A, 32'h0000_0001);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_0001);
    ev(1'b0);
    ev(1'b0);
    chk(na, 16'h0003);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_0021);
    ev(1'b0);
    chk(na, 16'h0003);
    rd_c(`ECTQ_OFS_CNT_A, 16'hfffe);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_0000);
    wr_t(`ECTQ_OFS_CFG, 32'h0000_062e);
    wr_t(`ECTQ_OFS_ILR_A, 32'h0000_0020);
    wr_t(`ECTQ_OFS_ILR_B, 32'h0000_0005);
    wr_t(`ECTQ_OFS_MATCH_B, 32'h0000_0000);
    wr_t(`ECTQ_OFS_CTL, 32'h0000_0101);
    wr_t(`ECTQ_OFS_MATCH_A, 32'h0000_0000);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0021);
    wr_t(`ECTQ_OFS_PRE_A, 32'h0000_0001);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0022);
    ev(1'b0);
    rd_c(`ECTQ_OFS_CNT_A, 16'h0022);
    ev(1'b1);
    rd_c(`ECTQ_OFS_CNT_B, 16'h0003);
    chk(nb, 16'h0001);
    stop_test;
  end
endmodule

`default_nettype wire
